// ### hdl/isu_cfg.svh
`ifndef ISU_CFG_SVH
`define ISU_CFG_SVH
`define ISU_DWORD_W       64
`define ISU_WORD_W        32
`define ISU_WORD_SIGN_BIT 31
`define ISU_DWORD_SIGN_BIT 63
`define ISU_IMM_W         5
`define ISU_DCNT_W        6
`define ISU_PLUS32        6'h20
`define ISU_RESULT_RST    64'h0000000000000000
`endif

// ### hdl/isu_pkg.sv
package isu_pkg;
	typedef enum logic [3:0] {
		word_shift_left_logical_imm,
		word_shift_right_logical_imm,
		word_shift_right_arith_imm,
		word_shift_left_logical_var,
		word_shift_right_logical_var,
		word_shift_right_arith_var,
		dword_shift_left_logical_imm,
		dword_shift_right_logical_imm,
		dword_shift_right_arith_imm,
		dword_shift_left_logical_var,
		dword_shift_right_logical_var,
		dword_shift_right_arith_var,
		dword_shift_left_logical_plus32,
		dword_shift_right_logical_plus32,
		dword_shift_right_arith_plus32
	} isu_op_t;
endpackage

// ### hdl/isu_shift_unit.sv
`include "isu_cfg.svh"
module isu_shift_unit
	import isu_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        op_valid,
	input  isu_op_t          op_code,
	input  wire logic        mode_64,
	input  wire logic [63:0] first_source_field,
	input  wire logic [63:0] second_source_field,
	input  wire logic [4:0]  shift_amount_field,
	output logic             result_valid,
	output logic [63:0]      result
);
	logic [5:0]  next_count;
	logic        next_is_word;
	logic        next_left;
	logic        next_arith;
	logic [31:0] word_res;
	logic [63:0] dword_res;
	logic [63:0] next_result;

	// decode operation into count, width and direction
	always_comb begin
		next_count   = {1'b0, shift_amount_field};
		next_is_word = 1'b0;
		next_left    = 1'b0;
		next_arith   = 1'b0;
		case (op_code)
			word_shift_left_logical_imm: begin
				next_is_word = 1'b1;
				next_left    = 1'b1;
			end
			word_shift_right_logical_imm: begin
				next_is_word = 1'b1;
			end
			word_shift_right_arith_imm: begin
				next_is_word = 1'b1;
				next_arith   = 1'b1;
			end
			word_shift_left_logical_var: begin
				next_is_word = 1'b1;
				next_left    = 1'b1;
				next_count   = {1'b0, first_source_field[4:0]};
			end
			word_shift_right_logical_var: begin
				next_is_word = 1'b1;
				next_count   = {1'b0, first_source_field[4:0]};
			end
			word_shift_right_arith_var: begin
				next_is_word = 1'b1;
				next_arith   = 1'b1;
				next_count   = {1'b0, first_source_field[4:0]};
			end
			dword_shift_left_logical_imm: begin
				next_left = 1'b1;
			end
			dword_shift_right_logical_imm: begin
				next_left = 1'b0;
			end
			dword_shift_right_arith_imm: begin
				next_arith = 1'b1;
			end
			dword_shift_left_logical_var: begin
				next_left  = 1'b1;
				next_count = first_source_field[5:0];
			end
			dword_shift_right_logical_var: begin
				next_count = first_source_field[5:0];
			end
			dword_shift_right_arith_var: begin
				next_arith = 1'b1;
				next_count = first_source_field[5:0];
			end
			dword_shift_left_logical_plus32: begin
				next_left  = 1'b1;
				next_count = `ISU_PLUS32 + {1'b0, shift_amount_field};
			end
			dword_shift_right_logical_plus32: begin
				next_count = `ISU_PLUS32 + {1'b0, shift_amount_field};
			end
			dword_shift_right_arith_plus32: begin
				next_arith = 1'b1;
				next_count = `ISU_PLUS32 + {1'b0, shift_amount_field};
			end
			default: begin
				next_count = 6'h00;
			end
		endcase
	end

	// word path works on the low word; source is assumed sign-extended
	always_comb begin
		if (next_left) begin
			word_res = second_source_field[31:0] << next_count[4:0];
		end else if (next_arith) begin
			word_res = $signed(second_source_field[31:0]) >>> next_count[4:0];
		end else begin
			word_res = second_source_field[31:0] >> next_count[4:0];
		end
	end

	// doubleword path over the full operand
	always_comb begin
		if (next_left) begin
			dword_res = second_source_field << next_count;
		end else if (next_arith) begin
			dword_res = $signed(second_source_field) >>> next_count;
		end else begin
			dword_res = second_source_field >> next_count;
		end
	end

	// word results widen by sign in 64-bit mode, by zeros otherwise
	always_comb begin
		if (next_is_word) begin
			next_result = {mode_64 ? {32{word_res[31]}} : 32'h00000000, word_res};
		end else begin
			next_result = dword_res;
		end
	end

	// result register toward writeback
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			result <= `ISU_RESULT_RST;
		end else if (op_valid) begin
			result <= next_result;
		end
	end

	// valid follows the request by one cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			result_valid <= 1'b0;
		end else begin
			result_valid <= op_valid;
		end
	end

	a_valid_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid |=> result_valid)
		else $error("result_valid did not follow op_valid");
	a_sll_imm: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == word_shift_left_logical_imm && !mode_64 |=>
		result == {32'h00000000, $past(second_source_field[31:0]) << $past(shift_amount_field)})
		else $error("word left immediate wrong");
	a_srl_imm: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == word_shift_right_logical_imm && !mode_64 |=>
		result[31:0] == ($past(second_source_field[31:0]) >> $past(shift_amount_field)))
		else $error("word right logical wrong");
	a_sra_imm: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == word_shift_right_arith_imm |=>
		result[31:0] == 32'($signed($past(second_source_field[31:0])) >>> $past(shift_amount_field)))
		else $error("word right arithmetic wrong");
	a_var_five: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == word_shift_left_logical_var |=>
		result[31:0] == ($past(second_source_field[31:0]) << $past(first_source_field[4:0])))
		else $error("word variable count not five bits");
	a_dword_shift_left_logical_imm_imm: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_left_logical_imm |=>
		result == ($past(second_source_field) << $past(shift_amount_field)))
		else $error("dword left immediate wrong");
	a_dword_shift_right_logical_imm_imm: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_logical_imm |=>
		result == ($past(second_source_field) >> $past(shift_amount_field)))
		else $error("dword right logical wrong");
	a_dword_shift_right_arith_imm_imm: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_arith_imm |=>
		result == 64'($signed($past(second_source_field)) >>> $past(shift_amount_field)))
		else $error("dword right arithmetic wrong");
	a_dvar_six: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_logical_var |=>
		result == ($past(second_source_field) >> $past(first_source_field[5:0])))
		else $error("dword variable count not six bits");
	a_dword_shift_left_logical_imm_p32: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_left_logical_plus32 |=>
		result[31:0] == 32'h00000000)
		else $error("dword left plus32 low half not zero");
	a_dword_shift_right_logical_imm_p32: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_logical_plus32 |=>
		result[63:32] == 32'h00000000)
		else $error("dword right plus32 high half not zero");
	a_dword_shift_right_arith_imm_p32: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_arith_plus32 |=>
		result[63:32] == {32{$past(second_source_field[63])}})
		else $error("dword arith plus32 sign fill wrong");
	a_word_sext: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && mode_64 && op_code inside {[word_shift_left_logical_imm:word_shift_right_arith_var]} |=>
		result[63:32] == {32{result[31]}})
		else $error("word result not sign extended");
	a_hold_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!op_valid |=> $stable(result))
		else $error("result changed without request");

	// value checks for three variable forms, half checks for plus-32 and for word zero fill, and reset clearing
	a_word_shift_right_arith_var_var: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == word_shift_right_arith_var |=>
		result[31:0] == 32'($signed($past(second_source_field[31:0])) >>> $past(first_source_field[4:0])))
		else $error("word variable arithmetic wrong");
	a_dword_shift_left_logical_var_var: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_left_logical_var |=>
		result == ($past(second_source_field) << $past(first_source_field[5:0])))
		else $error("dword variable left wrong");
	a_dword_shift_right_arith_var_var: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_arith_var |=>
		result == 64'($signed($past(second_source_field)) >>> $past(first_source_field[5:0])))
		else $error("dword variable arithmetic wrong");
	a_dword_shift_left_logical_imm_p32_hi: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_left_logical_plus32 |=>
		result[63:32] == ($past(second_source_field[31:0]) << $past(shift_amount_field)))
		else $error("dword left plus32 high half wrong");
	a_dword_shift_right_logical_imm_p32_lo: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_logical_plus32 |=>
		result[31:0] == ($past(second_source_field[63:32]) >> $past(shift_amount_field)))
		else $error("dword right plus32 low half wrong");
	a_word_zext: assert property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && !mode_64 && op_code inside {[word_shift_left_logical_imm:word_shift_right_arith_var]} |=>
		result[63:32] == 32'h00000000)
		else $error("word result upper half not zero");
	a_reset_clear: assert property (@(posedge ref_clk)
		sys_rst |-> result == `ISU_RESULT_RST && !result_valid)
		else $error("result not cleared in reset");

	c_word_sra: cover property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == word_shift_right_arith_var && second_source_field[31]);
	c_dword_p32: cover property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_right_arith_plus32 && shift_amount_field == 5'h1F);
	c_dvar_max: cover property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && op_code == dword_shift_left_logical_var && first_source_field[5:0] == 6'h3F);
	c_back2back: cover property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid ##1 op_valid);
	c_word_zext: cover property (@(posedge ref_clk) disable iff (sys_rst)
		op_valid && !mode_64 && op_code == word_shift_right_arith_imm && second_source_field[31]);
endmodule // isu_shift_unit

// ### sim/integer_shift_unit_bench.sv
module integer_shift_unit_bench
	import isu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [63:0] ones  = 64'hFFFFFFFFFFFFFFFF;
	localparam logic [63:0] neg_w = 64'hFFFFFFFF87654321;
	localparam logic [63:0] pos_w = 64'h0000000043218765;
	localparam logic [63:0] dw    = 64'h8123456789ABCDEF;

	logic        ref_clk;
	logic        sys_rst;
	logic        op_valid;
	isu_op_t     op_code;
	logic        mode_64;
	logic [63:0] first_source_field;
	logic [63:0] second_source_field;
	logic [4:0]  shift_amount_field;
	logic        result_valid;
	logic [63:0] result;
	logic [63:0] last_exp;
	int          num_errors;
	int          check_count;

	isu_shift_unit uut (
		.ref_clk            (ref_clk),
		.sys_rst            (sys_rst),
		.op_valid           (op_valid),
		.op_code            (op_code),
		.mode_64            (mode_64),
		.first_source_field (first_source_field),
		.second_source_field(second_source_field),
		.shift_amount_field (shift_amount_field),
		.result_valid       (result_valid),
		.result             (result)
	);

	// 250 MHz clock
	always #2 ref_clk = ~ref_clk;

	// reference result: count source and fill kind chosen per operation
	function automatic logic [63:0] model(isu_op_t op, logic m, logic [63:0] a, logic [63:0] b, logic [4:0] s);
		logic [31:0] w;
		logic [5:0]  c;
		case (op)
			word_shift_left_logical_var, word_shift_right_logical_var, word_shift_right_arith_var: c = {1'h0, a[4:0]};
			dword_shift_left_logical_var, dword_shift_right_logical_var, dword_shift_right_arith_var: c = a[5:0];
			dword_shift_left_logical_plus32, dword_shift_right_logical_plus32, dword_shift_right_arith_plus32: c = {1'h1, s};
			isu_op_t'(4'hF): c = 6'h00;
			default: c = {1'h0, s};
		endcase
		case (op)
			word_shift_left_logical_imm, word_shift_left_logical_var: w = b[31:0] << c;
			word_shift_right_logical_imm, word_shift_right_logical_var: w = b[31:0] >> c;
			word_shift_right_arith_imm, word_shift_right_arith_var: w = $signed(b[31:0]) >>> c;
			dword_shift_left_logical_imm, dword_shift_left_logical_var, dword_shift_left_logical_plus32: return b << c;
			dword_shift_right_arith_imm, dword_shift_right_arith_var, dword_shift_right_arith_plus32: return $signed(b) >>> c;
			default: return b >> c;
		endcase
		return {m ? {32{w[31]}} : 32'h0, w};
	endfunction

	task automatic check64(logic [63:0] got, logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check1(logic got, logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one request, answered one cycle later; strobe left high for back-to-back use
	task automatic issue(isu_op_t op, logic m, logic [63:0] a, logic [63:0] b, logic [4:0] s);
		last_exp = model(op, m, a, b, s);
		op_valid = 1'h1;
		op_code = op;
		mode_64 = m;
		first_source_field = a;
		second_source_field = b;
		shift_amount_field = s;
		@(posedge ref_clk);
		#1;
		check1(result_valid, 1'h1);
		check64(result, last_exp);
	endtask

	task automatic idle;
		op_valid = 1'h0;
		@(posedge ref_clk);
		#1;
		check1(result_valid, 1'h0);
		check64(result, last_exp);
	endtask

	task automatic sweep(int lo, int hi, logic m, logic [63:0] a, logic [63:0] b, logic [4:0] s);
		for (int i = lo; i <= hi; i++) begin
			issue(isu_op_t'(i), m, a, b, s);
		end
	endtask

	task automatic sc_word_imm;
		sweep(0, 2, 1'h1, ones, neg_w, 5'h00);
		sweep(0, 2, 1'h1, ones, neg_w, 5'h1F);
		sweep(0, 2, 1'h0, ones, pos_w, 5'h01);
		sweep(0, 2, 1'h1, ones, pos_w, 5'h01);
	endtask

	task automatic sc_word_var;
		sweep(3, 5, 1'h1, 64'hFFFFFFFFFFFFFFE7, neg_w, 5'h1F);
		sweep(3, 5, 1'h1, 64'h00000000000000E0, neg_w, 5'h1F);
		sweep(3, 5, 1'h0, 64'h000000000000003F, neg_w, 5'h00);
	endtask

	task automatic sc_dword_imm;
		sweep(6, 8, 1'h0, ones, dw, 5'h00);
		sweep(6, 8, 1'h1, ones, dw, 5'h1F);
		sweep(6, 8, 1'h1, ones, ~dw, 5'h07);
	endtask

	task automatic sc_dword_var;
		sweep(9, 11, 1'h1, 64'hFFFFFFFFFFFFFFBF, dw, 5'h15);
		sweep(9, 11, 1'h1, 64'hFFFFFFFFFFFFFFC0, dw, 5'h15);
		sweep(9, 11, 1'h0, 64'h00000000000000A1, dw, 5'h00);
	endtask

	task automatic sc_plus32;
		sweep(12, 14, 1'h0, ones, dw, 5'h00);
		sweep(12, 14, 1'h1, ones, dw, 5'h1F);
		sweep(12, 14, 1'h1, ones, ~dw, 5'h05);
		issue(isu_op_t'(4'hF), 1'h1, ones, dw, 5'h1F);
	endtask

	// result holds between requests, then a reset in mid-run clears it
	task automatic sc_hold_reset;
		issue(dword_shift_right_arith_plus32, 1'h1, ones, dw, 5'h03);
		idle();
		idle();
		issue(word_shift_left_logical_imm, 1'h1, ones, neg_w, 5'h04);
		sys_rst = 1'h1;
		last_exp = 64'h0;
		idle();
		sys_rst = 1'h0;
		idle();
		issue(word_shift_right_arith_var, 1'h1, 64'h0000000000000009, neg_w, 5'h00);
	endtask

	task automatic conclude;
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		{ref_clk, op_valid, mode_64, shift_amount_field} = '0;
		{first_source_field, second_source_field} = '0;
		op_code = word_shift_left_logical_imm;
		sys_rst = 1'h1;
		num_errors = 0;
		check_count = 0;
		last_exp = 64'h0;
		repeat (8) @(posedge ref_clk);
		#1;
		check1(result_valid, 1'h0);
		check64(result, 64'h0);
		sys_rst = 1'h0;
		sc_word_imm();
		sc_word_var();
		sc_dword_imm();
		sc_dword_var();
		sc_plus32();
		sc_hold_reset();
		conclude();
	end

	// watchdog against a hung run
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
endmodule // integer_shift_unit_bench
